// >>> sbcirq_pkg.sv
`default_nettype none
package sbcirq_pkg;

	// ****************************************
	// clock and widths
	// ****************************************
	localparam int CLK_MHZ = 50;
	localparam int HV_N = 4;
	localparam int LIN_N = 2;
	localparam int SPI_CNT_W = 6;

	// ****************************************
	// synchronised input vector layout
	// ****************************************
	localparam int SY_CAN_SUP = 0;
	localparam int SY_CAN_FLT = 1;
	localparam int SY_CAN_WAKE = 2;
	localparam int SY_CAN_IDLE = 3;
	localparam int SY_LIN_WAKE = 4;
	localparam int SY_OVERTEMP = 6;
	localparam int SY_MAIN_LOW = 7;
	localparam int SY_AUX_LOW = 8;
	localparam int SY_AUX_HIGH = 9;
	localparam int SY_BAT_LOW = 10;
	localparam int SY_BAT_HIGH = 11;
	localparam int SY_OVSD = 12;
	localparam int SY_SWITCHER = 13;
	localparam int SY_HV_OPEN = 14;
	localparam int SY_HV_SHORT = 18;
	localparam int SY_HV_PIN = 22;
	localparam int SY_W = 26;

	// ****************************************
	// interrupt status flag layout
	// ****************************************
	localparam int F_CAN_FAULT = 0;
	localparam int F_CAN_WAKE = 1;
	localparam int F_BUS_SILENCE = 2;
	localparam int F_LIN_WAKE = 3;
	localparam int F_WDOG = 5;
	localparam int F_OVERTEMP = 6;
	localparam int F_SEL_ERR = 7;
	localparam int F_POWER_ON = 8;
	localparam int F_SERIAL = 9;
	localparam int F_MAIN_LOW = 10;
	localparam int F_AUX_LOW = 11;
	localparam int F_AUX_HIGH = 12;
	localparam int F_BAT_LOW = 13;
	localparam int F_BAT_HIGH = 14;
	localparam int F_OVSD = 15;
	localparam int F_SWITCH = 16;
	localparam int F_HV_OPEN = 17;
	localparam int F_HV_SHORT = 21;
	localparam int F_HV_RISE = 25;
	localparam int F_HV_FALL = 29;
	localparam int FLAG_W = 33;

	// ****************************************
	// flag classes and reset values
	// ****************************************
	localparam logic [FLAG_W-1:0] ALWAYS_ON_MASK = 33'h0000081A0;
	localparam logic [FLAG_W-1:0] PRIORITY_MASK = 33'h00001E440;
	localparam logic [FLAG_W-1:0] REGULAR_MASK = 33'h1FE00001A;
	localparam logic [FLAG_W-1:0] FLAG_RST = 33'h000000000;
	localparam logic [SY_W-1:0] SYNC_RST = 26'h0000000;

	// ****************************************
	// legal serial frame lengths
	// ****************************************
	localparam logic [SPI_CNT_W-1:0] SPI_LEN_A = 6'h10;
	localparam logic [SPI_CNT_W-1:0] SPI_LEN_B = 6'h18;
	localparam logic [SPI_CNT_W-1:0] SPI_LEN_C = 6'h20;

endpackage : sbcirq_pkg
`default_nettype wire

// >>> sbcirq_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sbcirq_sync_if;
	import sbcirq_pkg::*;
	logic [SY_W-1:0] raw;
	logic [SY_W-1:0] level;
	logic [SY_W-1:0] rise;
	logic [SY_W-1:0] fall;
	modport sync_side (input raw, output level, output rise, output fall);
	modport user_side (output raw, input level, input rise, input fall);
endinterface : sbcirq_sync_if
`default_nettype wire

// >>> sbcirq_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sbcirq_sync (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	sbcirq_sync_if.sync_side sy // raw pins in, clean levels and edges out
);
	import sbcirq_pkg::*;

	logic [SY_W-1:0] s1_ff;
	logic [SY_W-1:0] s2_ff;
	logic [SY_W-1:0] s3_ff;
	logic [SY_W-1:0] stable_ff;
	logic [SY_W-1:0] rise_ff;
	logic [SY_W-1:0] fall_ff;
	logic [SY_W-1:0] nxt_stable;

	// ****************************************
	// accept a change only once stages two and three agree
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < SY_W; gi++) begin : g_bit
			assign nxt_stable[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : stable_ff[gi];
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_ff <= SYNC_RST;
			s2_ff <= SYNC_RST;
			s3_ff <= SYNC_RST;
			stable_ff <= SYNC_RST;
			rise_ff <= SYNC_RST;
			fall_ff <= SYNC_RST;
		end else begin
			s1_ff <= sy.raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			stable_ff <= nxt_stable;
			rise_ff <= nxt_stable & ~stable_ff;
			fall_ff <= ~nxt_stable & stable_ff;
		end
	end

	assign sy.level = stable_ff;
	assign sy.rise = rise_ff;
	assign sy.fall = fall_ff;

endmodule : sbcirq_sync
`default_nettype wire

// >>> sbcirq_top.sv
`timescale 1ns/1ps
`default_nettype none
module sbcirq_top #(
	parameter int SILENCE_TIMEOUT_US = 1000 // bus silence timeout in microseconds
) (
	input wire logic clk, // 50 MHz system clock
	input wire logic rst, // async system reset, active high
	input wire logic can_supply_status, // can supply status bit, async
	input wire logic can_fault_status, // can fault status bit, async
	input wire logic can_wake_det, // can bus wake detector, async
	input wire logic can_bus_idle, // can bus recessive, async
	input wire logic [sbcirq_pkg::LIN_N-1:0] lin_wake_det, // lin wake detectors, async
	input wire logic overtemp_det, // temperature over warning level, async
	input wire logic main_reg_low_det, // main regulator under 90 %, async
	input wire logic aux_low_det, // sensor supply output under 90 %, async
	input wire logic aux_high_det, // sensor supply output over 110 %, async
	input wire logic battery_low_det, // monitored source under threshold, async
	input wire logic battery_high_det, // monitored source over threshold, async
	input wire logic overvoltage_det, // battery overvoltage shutdown, async
	input wire logic switcher_state_bit, // switching regulator status, async
	input wire logic [sbcirq_pkg::HV_N-1:0] hv_open_det, // open-load detectors, async
	input wire logic [sbcirq_pkg::HV_N-1:0] hv_short_det, // short detectors, async
	input wire logic [sbcirq_pkg::HV_N-1:0] high_voltage_io_pin, // pin levels, async
	input wire logic can_active, // can transceiver in active mode
	input wire logic [sbcirq_pkg::LIN_N-1:0] lin_active, // lin transceivers active
	input wire logic main_reg_on, // main regulator switched on
	input wire logic sleep_mode, // device in sleep mode
	input wire logic [sbcirq_pkg::HV_N-1:0] hv_driver_on, // high or low side driver on
	input wire logic [sbcirq_pkg::HV_N-1:0] hv_wake_cfg, // pin configured as wake input
	input wire logic watchdog_timeout_mode, // watchdog in timeout mode
	input wire logic watchdog_overflow, // watchdog overflow pulse
	input wire logic selective_wake_error, // error frame seen pulse
	input wire logic off_mode_exit, // leaving off mode pulse
	input wire logic watchdog_mode_code_bad, // illegal watchdog mode code pulse
	input wire logic watchdog_period_code_bad, // illegal watchdog period code pulse
	input wire logic operating_mode_code_bad, // illegal operating mode code pulse
	input wire logic locked_write, // write to locked register pulse
	input wire logic spi_frame_end, // serial frame finished pulse
	input wire logic [sbcirq_pkg::SPI_CNT_W-1:0] spi_clock_count, // clocks in frame
	input wire logic sleep_request, // sleep mode requested pulse
	input wire logic [sbcirq_pkg::FLAG_W-1:0] irq_enable, // per-flag enables
	input wire logic [sbcirq_pkg::FLAG_W-1:0] irq_clear, // write-one-to-clear pulse
	output logic [sbcirq_pkg::FLAG_W-1:0] irq_status, // pending flags
	output logic irq_out_main_o, // main irq pin drive value
	output logic irq_out_main_oe, // main irq pin pulled low
	output logic irq_out_priority_o, // priority irq pin drive value
	output logic irq_out_priority_oe, // priority irq pin pulled low
	output logic can_receive_out, // can receive output, low on wake
	output logic lin_first_receive_out, // first lin receive output
	output logic lin_second_receive_out, // second lin receive output
	output logic system_reset_req, // system reset request pulse
	output logic sleep_grant, // sleep entry allowed pulse
	output logic reset_mode_req // sleep refused, flags pending pulse
);
	import sbcirq_pkg::*;

	// longer than the timeout, so the flag fires one cycle past this count
	localparam logic [31:0] SILENCE_CYC = 32'(SILENCE_TIMEOUT_US * CLK_MHZ);

	sbcirq_sync_if sy ();

	logic [FLAG_W-1:0] flag_ff;
	logic [FLAG_W-1:0] nxt_flag;
	logic [FLAG_W-1:0] set_vec;
	logic [FLAG_W-1:0] gate_vec;
	logic [31:0] silence_cnt_ff;
	logic [31:0] nxt_silence_cnt;
	logic main_oe_ff;
	logic prio_oe_ff;
	logic sys_reset_ff;
	logic sleep_grant_ff;
	logic reset_mode_ff;
	logic silence_hit;
	logic wdog_second;
	logic serial_len_bad;
	logic serial_evt;
	logic no_regular_wake;
	logic sleep_ok;
	logic any_pending;

	// ****************************************
	// input synchronisation
	// ****************************************
	assign sy.raw = {high_voltage_io_pin, hv_short_det, hv_open_det, switcher_state_bit,
		overvoltage_det, battery_high_det, battery_low_det, aux_high_det, aux_low_det,
		main_reg_low_det, overtemp_det, lin_wake_det, can_bus_idle, can_wake_det,
		can_fault_status, can_supply_status};

	sbcirq_sync u_sync (
		.clk(clk),
		.rst(rst),
		.sy(sy)
	);

	// ****************************************
	// bus silence timer
	// ****************************************
	assign silence_hit = (silence_cnt_ff == SILENCE_CYC);
	assign nxt_silence_cnt = !sy.level[SY_CAN_IDLE] ? 32'h00000000 :
		(silence_cnt_ff > SILENCE_CYC) ? silence_cnt_ff : silence_cnt_ff + 32'h00000001;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			silence_cnt_ff <= 32'h00000000;
		end else begin
			silence_cnt_ff <= nxt_silence_cnt;
		end
	end

	// ****************************************
	// source events
	// ****************************************
	assign serial_len_bad = spi_frame_end && (spi_clock_count != SPI_LEN_A) &&
		(spi_clock_count != SPI_LEN_B) && (spi_clock_count != SPI_LEN_C);
	assign serial_evt = watchdog_mode_code_bad | watchdog_period_code_bad |
		operating_mode_code_bad | locked_write | serial_len_bad;
	assign wdog_second = watchdog_overflow && watchdog_timeout_mode && flag_ff[F_WDOG];

	// status bits setting, not their level, so a stuck fault asks only once
	assign set_vec[F_CAN_FAULT] = sy.rise[SY_CAN_SUP] | sy.rise[SY_CAN_FLT];
	assign set_vec[F_CAN_WAKE] = sy.rise[SY_CAN_WAKE] & ~can_active;
	assign set_vec[F_BUS_SILENCE] = silence_hit;
	assign set_vec[F_WDOG] = watchdog_overflow & watchdog_timeout_mode;
	assign set_vec[F_OVERTEMP] = sy.rise[SY_OVERTEMP];
	assign set_vec[F_SEL_ERR] = selective_wake_error;
	assign set_vec[F_POWER_ON] = off_mode_exit;
	assign set_vec[F_SERIAL] = serial_evt;
	// regulator is off in sleep, its detector is meaningless there
	assign set_vec[F_MAIN_LOW] = sy.rise[SY_MAIN_LOW] & main_reg_on & ~sleep_mode;
	assign set_vec[F_AUX_LOW] = sy.rise[SY_AUX_LOW];
	assign set_vec[F_AUX_HIGH] = sy.rise[SY_AUX_HIGH];
	assign set_vec[F_BAT_LOW] = sy.rise[SY_BAT_LOW];
	assign set_vec[F_BAT_HIGH] = sy.rise[SY_BAT_HIGH];
	assign set_vec[F_OVSD] = sy.rise[SY_OVSD];
	assign set_vec[F_SWITCH] = sy.rise[SY_SWITCHER] | sy.fall[SY_SWITCHER];

	genvar li;
	generate
		for (li = 0; li < LIN_N; li++) begin : g_lin
			assign set_vec[F_LIN_WAKE+li] = sy.rise[SY_LIN_WAKE+li] & ~lin_active[li];
		end
	endgenerate

	genvar hi;
	generate
		for (hi = 0; hi < HV_N; hi++) begin : g_hv
			assign set_vec[F_HV_OPEN+hi] = sy.rise[SY_HV_OPEN+hi] & hv_driver_on[hi];
			assign set_vec[F_HV_SHORT+hi] = sy.rise[SY_HV_SHORT+hi] & hv_driver_on[hi];
			assign set_vec[F_HV_RISE+hi] = sy.rise[SY_HV_PIN+hi] & hv_wake_cfg[hi];
			assign set_vec[F_HV_FALL+hi] = sy.fall[SY_HV_PIN+hi] & hv_wake_cfg[hi];
		end
	endgenerate

	// ****************************************
	// sticky flags, set wins over clear
	// ****************************************
	assign gate_vec = set_vec & (irq_enable | ALWAYS_ON_MASK);
	assign nxt_flag = (flag_ff & ~irq_clear) | gate_vec;
	assign any_pending = |flag_ff;

	// ****************************************
	// sleep protection
	// ****************************************
	assign no_regular_wake = ~|(irq_enable & REGULAR_MASK);
	assign sleep_ok = sleep_request && !no_regular_wake && !any_pending;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_ff <= FLAG_RST;
			main_oe_ff <= 1'b0;
			prio_oe_ff <= 1'b0;
			sys_reset_ff <= 1'b0;
			sleep_grant_ff <= 1'b0;
			reset_mode_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
			main_oe_ff <= |nxt_flag;
			prio_oe_ff <= |(nxt_flag & PRIORITY_MASK);
			sys_reset_ff <= wdog_second | (sleep_request & no_regular_wake);
			sleep_grant_ff <= sleep_ok;
			reset_mode_ff <= sleep_request & !no_regular_wake & any_pending;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign irq_status = flag_ff;
	assign irq_out_main_o = 1'b0;
	assign irq_out_main_oe = main_oe_ff;
	assign irq_out_priority_o = 1'b0;
	assign irq_out_priority_oe = prio_oe_ff;
	assign can_receive_out = ~flag_ff[F_CAN_WAKE];
	assign lin_first_receive_out = ~flag_ff[F_LIN_WAKE];
	assign lin_second_receive_out = ~flag_ff[F_LIN_WAKE+1];
	assign system_reset_req = sys_reset_ff;
	assign sleep_grant = sleep_grant_ff;
	assign reset_mode_req = reset_mode_ff;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_wdog_unmasked;
		(watchdog_overflow && watchdog_timeout_mode && !irq_enable[F_WDOG]) |=> irq_status[F_WDOG];
	endproperty
	a_wdog_unmasked: assert property (p_wdog_unmasked) else $error("watchdog flag not set");

	property p_gated_off;
		(!irq_enable[F_OVERTEMP] && !irq_status[F_OVERTEMP]) |=> !irq_status[F_OVERTEMP];
	endproperty
	a_gated_off: assert property (p_gated_off) else $error("disabled flag set");

	property p_rx_follow;
		irq_status[F_CAN_WAKE] |-> !can_receive_out;
	endproperty
	a_rx_follow: assert property (p_rx_follow) else $error("receive output not low");

	property p_rx_release;
		$fell(irq_status[F_CAN_WAKE]) |-> can_receive_out && $past(irq_clear[F_CAN_WAKE]);
	endproperty
	a_rx_release: assert property (p_rx_release) else $error("receive release wrong");

	property p_wdog_second;
		(watchdog_overflow && watchdog_timeout_mode && irq_status[F_WDOG]) |=> system_reset_req;
	endproperty
	a_wdog_second: assert property (p_wdog_second) else $error("no reset on overflow");

	property p_spi_len;
		(spi_frame_end && spi_clock_count == 6'h14 && irq_enable[F_SERIAL])
			|=> irq_status[F_SERIAL];
	endproperty
	a_spi_len: assert property (p_spi_len) else $error("bad frame not flagged");

	property p_power_on;
		off_mode_exit |=> irq_status[F_POWER_ON] ##1
			(irq_status[F_POWER_ON] || $past(irq_clear[F_POWER_ON]));
	endproperty
	a_power_on: assert property (p_power_on) else $error("power-on flag missing");

	property p_pin_main;
		(|irq_status) |-> irq_out_main_oe;
	endproperty
	a_pin_main: assert property (p_pin_main) else $error("main pin not low");

	property p_pin_release;
		(irq_status == FLAG_RST) |-> !irq_out_main_oe && !irq_out_priority_oe;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("pins not released");

	property p_sticky;
		(irq_status[F_BAT_LOW] && !irq_clear[F_BAT_LOW]) |=> irq_status[F_BAT_LOW];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped");

	property p_sleep_guard;
		(sleep_request && (irq_enable & REGULAR_MASK) == FLAG_RST) |=> system_reset_req && !sleep_grant;
	endproperty
	a_sleep_guard: assert property (p_sleep_guard) else $error("sleep not guarded");

	property p_prio_pin;
		irq_status[F_OVERTEMP] |-> irq_out_priority_oe;
	endproperty
	a_prio_pin: assert property (p_prio_pin) else $error("priority pin idle");

	c_silence: cover property (set_vec[F_BUS_SILENCE]);
	c_wdog_reset: cover property (wdog_second);
	c_sleep_ok: cover property (sleep_grant);
	c_hv_rise: cover property (irq_status[F_HV_RISE]);

endmodule : sbcirq_top
`default_nettype wire

// >>> sbcirq_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host servicing the main interrupt pin
// ****************************************
module sbcirq_host (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic irq_main_n, // resolved main pin level
	input wire logic [sbcirq_pkg::FLAG_W-1:0] irq_status, // flags read back
	input wire logic service_en, // host allowed to service
	input wire logic [sbcirq_pkg::FLAG_W-1:0] clr_mask, // bits host may clear
	output logic [sbcirq_pkg::FLAG_W-1:0] irq_clear // write-one-to-clear pulse
);
	import sbcirq_pkg::*;
	// a write is always followed by an idle cycle, so a clear is never held
	// rising edge, so the bench's falling-edge enable is settled when read
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_clear <= '0;
		end else if (service_en && !irq_main_n && irq_clear == '0) begin
			irq_clear <= irq_status & clr_mask;
		end else begin
			irq_clear <= '0;
		end
	end
endmodule : sbcirq_host
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sbcirq_pkg::*;
	logic clk, rst, can_bus_idle, can_active, main_reg_on, sleep_mode, wd_tmo, service_en;
	logic [10:0] ad;
	logic [1:0] lin_wake, lin_active;
	logic [3:0] hv_open, hv_short, hv_pin, hv_drv, hv_wcfg;
	logic [8:0] pv;
	logic [5:0] spi_cnt;
	logic [32:0] irq_enable, irq_clear, irq_status, clr_mask;
	logic mo, moe, po, poe, can_rx, lin1_rx, lin2_rx, sys_rst, sleep_ok, rst_mode;
	int n_mismatch, total_checks, nr, ng, nm;
	// pull-ups to the supply when nobody pulls low
	wire main_n = moe ? mo : 1'b1;
	wire prio_n = poe ? po : 1'b1;
	int fm[11] = '{F_CAN_FAULT, F_CAN_FAULT, F_CAN_WAKE, F_OVERTEMP, F_MAIN_LOW, F_AUX_LOW,
		F_AUX_HIGH, F_BAT_LOW, F_BAT_HIGH, F_OVSD, F_SWITCH};
	logic [5:0] bad_len[4] = '{6'h0F, 6'h14, 6'h1F, 6'h21};

	sbcirq_top #(.SILENCE_TIMEOUT_US(2)) i_sbcirq_top (.clk(clk), .rst(rst),
		.can_supply_status(ad[0]), .can_fault_status(ad[1]), .can_wake_det(ad[2]),
		.can_bus_idle(can_bus_idle), .lin_wake_det(lin_wake), .overtemp_det(ad[3]),
		.main_reg_low_det(ad[4]), .aux_low_det(ad[5]), .aux_high_det(ad[6]),
		.battery_low_det(ad[7]), .battery_high_det(ad[8]), .overvoltage_det(ad[9]),
		.switcher_state_bit(ad[10]), .hv_open_det(hv_open), .hv_short_det(hv_short),
		.high_voltage_io_pin(hv_pin), .can_active(can_active), .lin_active(lin_active),
		.main_reg_on(main_reg_on), .sleep_mode(sleep_mode), .hv_driver_on(hv_drv),
		.hv_wake_cfg(hv_wcfg), .watchdog_timeout_mode(wd_tmo), .watchdog_overflow(pv[0]),
		.selective_wake_error(pv[1]), .off_mode_exit(pv[2]), .watchdog_mode_code_bad(pv[3]),
		.watchdog_period_code_bad(pv[4]), .operating_mode_code_bad(pv[5]),
		.locked_write(pv[6]), .spi_frame_end(pv[7]), .spi_clock_count(spi_cnt),
		.sleep_request(pv[8]), .irq_enable(irq_enable), .irq_clear(irq_clear),
		.irq_status(irq_status), .irq_out_main_o(mo), .irq_out_main_oe(moe),
		.irq_out_priority_o(po), .irq_out_priority_oe(poe), .can_receive_out(can_rx),
		.lin_first_receive_out(lin1_rx), .lin_second_receive_out(lin2_rx),
		.system_reset_req(sys_rst), .sleep_grant(sleep_ok), .reset_mode_req(rst_mode));

	sbcirq_host i_sbcirq_host (.clk(clk), .rst(rst), .irq_main_n(main_n),
		.irq_status(irq_status), .service_en(service_en), .clr_mask(clr_mask),
		.irq_clear(irq_clear));

	// ****************************************
	// helpers
	// ****************************************
	task automatic complete_run();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	task automatic chk(string nm_s, logic [32:0] seen, logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm_s, exp, seen);
		end
	endtask : chk

	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic state(logic [32:0] e);
		chk("status", irq_status, e);
		chk("main pin", main_n, !(|e));
		chk("priority pin", prio_n, !(|(e & PRIORITY_MASK)));
		chk("can rx", can_rx, !e[F_CAN_WAKE]);
		chk("lin1 rx", lin1_rx, !e[F_LIN_WAKE]);
		chk("lin2 rx", lin2_rx, !e[F_LIN_WAKE+1]);
	endtask : state

	task automatic service(logic [32:0] m);
		int k;
		k = 0;
		clr_mask = m;
		service_en = 1'b1;
		while ((irq_status & m) != '0 && k < 20) begin
			cyc(1);
			k++;
		end
		service_en = 1'b0;
		cyc(2);
	endtask : service

	// counts the one-cycle answers over the four cycles after the pulse
	task automatic pulse(int i, logic [5:0] cnt);
		spi_cnt = cnt;
		pv[i] = 1'b1;
		cyc(1);
		pv[i] = 1'b0;
		nr = 0;
		ng = 0;
		nm = 0;
		repeat (4) begin
			nr += (sys_rst === 1'b1);
			ng += (sleep_ok === 1'b1);
			nm += (rst_mode === 1'b1);
			cyc(1);
		end
	endtask : pulse

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_watchdog();
		irq_enable = '0;
		wd_tmo = 1'b0;
		pulse(0, 6'h00);
		state('0);
		wd_tmo = 1'b1;
		pulse(0, 6'h00);
		state(33'h1 << F_WDOG);
		chk("reset early", 33'(nr), 33'h0);
		pulse(0, 6'h00);
		chk("reset second", 33'(nr), 33'h1);
		service('1);
		state('0);
		wd_tmo = 1'b0;
		pulse(1, 6'h00);
		pulse(2, 6'h00);
		pulse(6, 6'h00);
		state((33'h1 << F_SEL_ERR) | (33'h1 << F_POWER_ON));
		irq_enable = '1;
		service('1);
	endtask : t_watchdog

	task automatic t_serial();
		pulse(7, SPI_LEN_A);
		pulse(7, SPI_LEN_B);
		pulse(7, SPI_LEN_C);
		state('0);
		for (int i = 0; i < 4; i++) begin
			pulse(7, bad_len[i]);
			state(33'h1 << F_SERIAL);
			service('1);
		end
		for (int i = 3; i < 7; i++) begin
			pulse(i, 6'h00);
			state(33'h1 << F_SERIAL);
			service('1);
		end
	endtask : t_serial

	task automatic t_async();
		for (int i = 0; i < 11; i++) begin
			ad[i] = 1'b1;
			cyc(8);
			state(33'h1 << fm[i]);
			ad[i] = 1'b0;
			cyc(8);
			state(33'h1 << fm[i]);
			service('1);
			state('0);
		end
		ad[10] = 1'b1;
		cyc(8);
		service('1);
		ad[10] = 1'b0;
		cyc(8);
		state(33'h1 << F_SWITCH);
		service('1);
	endtask : t_async

	task automatic t_gating();
		irq_enable[F_OVERTEMP] = 1'b0;
		can_active = 1'b1;
		main_reg_on = 1'b0;
		lin_active = 2'h3;
		hv_drv = 4'h0;
		hv_wcfg = 4'h0;
		ad = 11'h01C;
		lin_wake = 2'h3;
		{hv_open, hv_short, hv_pin} = 12'hFFF;
		cyc(8);
		state('0);
		ad = '0;
		lin_wake = 2'h0;
		{hv_open, hv_short, hv_pin} = 12'h000;
		cyc(8);
		main_reg_on = 1'b1;
		sleep_mode = 1'b1;
		ad[4] = 1'b1;
		cyc(8);
		state('0);
		ad[4] = 1'b0;
		cyc(8);
		{can_active, sleep_mode, lin_active, hv_drv, hv_wcfg} = 12'h0FF;
		irq_enable = '1;
	endtask : t_gating

	task automatic t_lin_hv();
		lin_wake = 2'h3;
		cyc(8);
		lin_wake = 2'h0;
		state(33'h3 << F_LIN_WAKE);
		service(33'h1 << F_LIN_WAKE);
		state(33'h1 << (F_LIN_WAKE + 1));
		service('1);
		{hv_open, hv_short, hv_pin} = 12'h124;
		cyc(8);
		state((33'h1 << F_HV_OPEN) | (33'h1 << (F_HV_SHORT + 1)) | (33'h1 << (F_HV_RISE + 2)));
		service('1);
		{hv_open, hv_short, hv_pin} = 12'h000;
		cyc(8);
		state(33'h1 << (F_HV_FALL + 2));
		service('1);
	endtask : t_lin_hv

	task automatic t_silence_sleep();
		can_bus_idle = 1'b1;
		cyc(60);
		state('0);
		cyc(70);
		state(33'h1 << F_BUS_SILENCE);
		can_bus_idle = 1'b0;
		service('1);
		pulse(8, 6'h00);
		chk("sleep grant", 33'(ng), 33'h1);
		irq_enable = ~REGULAR_MASK;
		pulse(8, 6'h00);
		chk("sleep reset", 33'(nr), 33'h1);
		irq_enable = '1;
		pulse(6, 6'h00);
		pulse(8, 6'h00);
		chk("sleep pending", 33'(nm), 33'h1);
		chk("sleep refused", 33'(ng), 33'h0);
		service('1);
	endtask : t_silence_sleep

	// ****************************************
	// run
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#100us;
		n_mismatch++;
		complete_run();
	end

	initial begin
		{rst, can_bus_idle, can_active, sleep_mode, wd_tmo, service_en} = 6'h20;
		{ad, lin_wake, hv_open, hv_short, hv_pin, pv, spi_cnt} = '0;
		{main_reg_on, lin_active, hv_drv, hv_wcfg} = 11'h4FF;
		{irq_enable, clr_mask} = {33'h1FFFFFFFF, 33'h0};
		n_mismatch = 0;
		total_checks = 0;
		cyc(10);
		state('0);
		rst = 1'b0;
		cyc(2);
		t_watchdog();
		t_serial();
		t_async();
		t_gating();
		t_lin_hv();
		t_silence_sleep();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
